// file: verilog/programmable_realtime_clock_counter.sv
// real-time clock counter core with its apb register slave
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module programmable_realtime_clock_counter #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trig_one,
  input wire logic ext_trig_two,
  input wire logic line_freq,
  output logic overflow_irq_req,
  output logic trigger_two_irq_req
);
  // control/status state
  logic run_q;
  logic [1:0] mode_q;
  logic [2:0] rate_q;
  logic ovf_en_q;
  logic overflow_flag_q;
  logic overrun_q;
  logic trigger_starts_run_q;
  logic t2_en_q;
  logic trigger_two_flag_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] preset_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic ovf_req_q;
  logic t2_req_q;

  // next values and decode
  logic access_w;
  logic csr_wr_w;
  logic preset_wr_w;
  logic mapped_w;
  logic tick_w;
  logic t2_evt_w;
  logic t2_set_w;
  logic hw_start_w;
  logic ovf_evt_w;
  logic mode_stop_w;
  logic run_written_w;
  logic run_d;
  logic run_rise_w;
  logic [1:0] mode_d;
  logic [2:0] rate_d;
  logic ovf_en_d;
  logic t2_en_d;
  logic tsr_d;
  logic overflow_flag_d;
  logic trigger_two_flag_d;
  logic overrun_d;
  logic capture_w;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] preset_d;
  logic ovf_req_d;
  logic t2_req_d;
  logic [15:0] csr_view_w;
  logic [31:0] prdata_d;
  logic pready_d;

  timebase_if tb ();

  rate_source u_rate_source (
    .clk(clk),
    .reset_n(reset_n),
    .ext_trig_one(ext_trig_one),
    .ext_trig_two(ext_trig_two),
    .line_freq(line_freq),
    .tb(tb.src)
  );

  assign tb.rate = rate_q; // RULE1
  assign tick_w = tb.count_tick;
  assign t2_evt_w = tb.trig_two_evt;

  // apb decode: one wait state, writes land on the edge that samples pready
  assign access_w = psel & penable & pready_q;
  assign csr_wr_w = access_w & pwrite & (paddr == rtc_pkg::ADDR_CSR);
  assign preset_wr_w = access_w & pwrite & (paddr == rtc_pkg::ADDR_PRESET);
  assign mapped_w = (paddr == rtc_pkg::ADDR_CSR) | (paddr == rtc_pkg::ADDR_PRESET) |
                    (paddr == rtc_pkg::ADDR_COUNT);
  assign pready_d = psel & penable & ~pready_q;

  // trigger two only counts while running or armed, in any mode
  assign t2_set_w = t2_evt_w & (run_q | trigger_starts_run_q); // RULE19
  assign hw_start_w = trigger_starts_run_q & t2_set_w; // RULE22 RULE10

  // overflow is the all-ones count taking another tick
  assign ovf_evt_w = run_q & tick_w & (&count_q);
  assign mode_stop_w = ovf_evt_w & (mode_q == rtc_pkg::MODE_SINGLE); // RULE5

  // run bit: software write, hardware start wins over a same-cycle clear
  assign run_written_w = csr_wr_w ? pwdata[rtc_pkg::CSR_RUN] : run_q; // RULE3
  assign run_d = hw_start_w | (run_written_w & ~mode_stop_w); // RULE4
  assign run_rise_w = run_d & ~run_q;

  // plain read/write fields
  assign mode_d = csr_wr_w ? pwdata[rtc_pkg::CSR_MODE_HI:rtc_pkg::CSR_MODE_LO] : mode_q; // RULE2
  assign rate_d = csr_wr_w ? pwdata[rtc_pkg::CSR_RATE_HI:rtc_pkg::CSR_RATE_LO] : rate_q;
  assign ovf_en_d = csr_wr_w ? pwdata[rtc_pkg::CSR_OVF_EN] : ovf_en_q;
  assign t2_en_d = csr_wr_w ? pwdata[rtc_pkg::CSR_T2_EN] : t2_en_q;

  // armed start is dropped by any run rise, including the one it caused
  assign tsr_d = (csr_wr_w ? pwdata[rtc_pkg::CSR_TSR] : trigger_starts_run_q) &
                 ~run_rise_w & ~hw_start_w; // RULE20 RULE22

  // flags are write-zero-to-clear; a hardware set in the same cycle wins
  assign overflow_flag_d = ovf_evt_w |
                           (overflow_flag_q & ~(csr_wr_w & ~pwdata[rtc_pkg::CSR_OVF_FLAG]) &
                            ~run_rise_w); // RULE21 RULE11 RULE16
  assign trigger_two_flag_d = t2_set_w |
                              (trigger_two_flag_q &
                               ~(csr_wr_w & ~pwdata[rtc_pkg::CSR_T2_FLAG]) &
                               ~(run_rise_w & ~trigger_starts_run_q)); // RULE19

  // overrun: new event while the old flag is still unserviced
  assign overrun_d = (ovf_evt_w & overflow_flag_q) | // RULE12
                     (t2_set_w & trigger_two_flag_q) | // RULE23
                     ((csr_wr_w ? pwdata[rtc_pkg::CSR_OVERRUN] : overrun_q) & ~run_rise_w);

  // modes 0 and 1 start from the preset, modes 2 and 3 from zero
  function automatic logic starts_from_preset(input logic [1:0] m);
    starts_from_preset = (m == rtc_pkg::MODE_SINGLE) || (m == rtc_pkg::MODE_REPEAT);
  endfunction

  // counter: zero while stopped, preset load on start in modes 0 and 1
  assign count_d = !run_d ? '0 : // RULE6
                   run_rise_w ? (starts_from_preset(mode_d) ? preset_q : '0) : // RULE9 RULE14
                   (ovf_evt_w && mode_q == rtc_pkg::MODE_REPEAT) ? preset_q : // RULE11
                   tick_w ? count_q + 1'b1 : count_q; // RULE17

  // capture in mode 2 takes priority over a colliding software write
  assign capture_w = t2_set_w & run_q & (mode_q == rtc_pkg::MODE_EVENT);
  assign preset_d = capture_w ? count_q : // RULE15
                    preset_wr_w ? pwdata[CNT_W-1:0] : preset_q;

  // requests follow flag and enable, so a cleared enable withdraws at once
  assign ovf_req_d = overflow_flag_d & ovf_en_d; // RULE7 RULE11 RULE16
  assign t2_req_d = trigger_two_flag_d & t2_en_d & ~ovf_req_d; // RULE24 RULE15

  // read view; bits 11:8 are reserved and read as zero
  assign csr_view_w = {trigger_two_flag_q, t2_en_q, trigger_starts_run_q, overrun_q,
                       4'h0, overflow_flag_q, ovf_en_q, rate_q, mode_q, run_q};
  assign prdata_d = (paddr == rtc_pkg::ADDR_CSR) ? {16'h0000, csr_view_w} :
                    (paddr == rtc_pkg::ADDR_PRESET) ? 32'(preset_q) :
                    (paddr == rtc_pkg::ADDR_COUNT) ? 32'(count_q) : 32'h00000000;

  // counter and control registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      mode_q <= rtc_pkg::MODE_SINGLE;
      rate_q <= rtc_pkg::RATE_STOP;
      ovf_en_q <= 1'b0;
      t2_en_q <= 1'b0;
      trigger_starts_run_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      trigger_two_flag_q <= 1'b0;
      overrun_q <= 1'b0;
      count_q <= '0;
      preset_q <= CNT_W'(rtc_pkg::PRESET_RST);
    end else begin
      run_q <= run_d;
      mode_q <= mode_d;
      rate_q <= rate_d;
      ovf_en_q <= ovf_en_d;
      t2_en_q <= t2_en_d;
      trigger_starts_run_q <= tsr_d;
      overflow_flag_q <= overflow_flag_d;
      trigger_two_flag_q <= trigger_two_flag_d;
      overrun_q <= overrun_d;
      count_q <= count_d;
      preset_q <= preset_d;
    end
  end

  // bus answer and interrupt request flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ovf_req_q <= 1'b0;
      t2_req_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pready_d & ~mapped_w;
      prdata_q <= pready_d ? prdata_d : 32'h00000000;
      ovf_req_q <= ovf_req_d;
      t2_req_q <= t2_req_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign overflow_irq_req = ovf_req_q;
  assign trigger_two_irq_req = t2_req_q;

  // checks: named steps of the counting sequences
  sequence run_overflow_s;
    run_q && ovf_evt_w && !csr_wr_w;
  endsequence

  sequence armed_trigger_s;
    trigger_starts_run_q && t2_evt_w && !run_q && !csr_wr_w;
  endsequence

  sequence event_capture_s;
    run_q && t2_evt_w && mode_q == rtc_pkg::MODE_EVENT && !csr_wr_w;
  endsequence

  sequence sw_start_s;
    csr_wr_w && pwdata[rtc_pkg::CSR_RUN] && !run_q;
  endsequence

  sequence armed_wait_s;
    trigger_starts_run_q && !run_q && !t2_evt_w && !csr_wr_w;
  endsequence

  idle_counter_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
    !run_q |-> count_q == '0)
    else $error("counter not zero while stopped");

  single_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    run_overflow_s ##0 (mode_q == rtc_pkg::MODE_SINGLE && !hw_start_w) |=> !run_q)
    else $error("mode 0 overflow did not stop the counter");

  repeat_reload_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
    run_overflow_s ##0 (mode_q == rtc_pkg::MODE_REPEAT) |=>
      run_q && count_q == $past(preset_q) && overflow_flag_q)
    else $error("mode 1 overflow did not reload and flag");

  event_keeps_running_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE17
    run_overflow_s ##0 (mode_q == rtc_pkg::MODE_EVENT) |=> run_q && count_q == '0)
    else $error("mode 2 overflow stopped or did not wrap");

  overrun_set_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
    (ovf_evt_w && overflow_flag_q) |=> overrun_q)
    else $error("lost overflow not reported as overrun");

  capture_value_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
    event_capture_s |=> preset_q == $past(count_q) && trigger_two_flag_q)
    else $error("trigger two capture missing");

  armed_start_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE22
    armed_trigger_s |=> run_q && !trigger_starts_run_q && trigger_two_flag_q)
    else $error("armed trigger did not start the counter");

  rise_clears_flag_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
    $rose(run_q) |-> !overflow_flag_q && !trigger_starts_run_q)
    else $error("run rise left overflow flag or armed start");

  enable_withdraw_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    (csr_wr_w && !pwdata[rtc_pkg::CSR_OVF_EN]) |=> !overflow_irq_req)
    else $error("overflow request not withdrawn");

  irq_priority_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE24
    overflow_irq_req |-> !trigger_two_irq_req)
    else $error("both interrupt requests raised together");

  apb_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && penable && !pready) |=> pready)
    else $error("apb access not answered after one wait state");

  run_start_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    sw_start_s |=> run_q)
    else $error("software start did not set run");

  start_load_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
    sw_start_s ##0 starts_from_preset(pwdata[rtc_pkg::CSR_MODE_HI:rtc_pkg::CSR_MODE_LO])
      |=> count_q == $past(preset_q))
    else $error("start did not load the preset");

  event_start_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
    sw_start_s ##0 !starts_from_preset(pwdata[rtc_pkg::CSR_MODE_HI:rtc_pkg::CSR_MODE_LO])
      |=> count_q == '0)
    else $error("event timing did not start from zero");

  run_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
    (run_q && mode_q != rtc_pkg::MODE_SINGLE && !csr_wr_w) |=> run_q)
    else $error("run cleared without a software write");

  count_step_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE17
    (run_q && tick_w && !ovf_evt_w && !csr_wr_w) |=> count_q == $past(count_q) + 1'b1)
    else $error("counter did not advance on a tick");

  stop_rate_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
    $past(rate_q) == rtc_pkg::RATE_STOP |-> !tick_w)
    else $error("tick seen with the stop rate selected");

  armed_wait_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
    armed_wait_s |=> trigger_starts_run_q && !run_q)
    else $error("armed start left its wait without a trigger");

  t2_rise_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE19
    ($rose(run_q) && !$past(trigger_starts_run_q)) |-> !trigger_two_flag_q)
    else $error("run rise left the trigger two flag set");

  overrun_t2_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE23
    (t2_set_w && trigger_two_flag_q) |=> overrun_q)
    else $error("lost trigger two not reported as overrun");

  ovf_flag_set_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
    ovf_evt_w |=> overflow_flag_q)
    else $error("overflow did not set its flag");

  t2_flag_set_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE19
    t2_set_w |=> trigger_two_flag_q)
    else $error("trigger two did not set its flag");

  ovf_request_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    overflow_irq_req == (overflow_flag_q && ovf_en_q))
    else $error("overflow request does not follow flag and enable");

  t2_request_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
    trigger_two_irq_req == (trigger_two_flag_q && t2_en_q && !overflow_irq_req))
    else $error("trigger two request does not follow flag and enable");

  single_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
    run_overflow_s ##0 (mode_q == rtc_pkg::MODE_SINGLE && !hw_start_w) |=> count_q == '0)
    else $error("mode 0 overflow did not zero the counter");

  spare_keeps_running_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
    run_overflow_s ##0 (mode_q == rtc_pkg::MODE_SPARE) |=> run_q && count_q == '0)
    else $error("mode 3 overflow stopped or did not wrap");

  pslverr_ready_a: assert property (@(posedge clk) disable iff (!reset_n)
    pslverr |-> pready)
    else $error("slave error outside an answer");

  read_idle_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pready |-> prdata == '0)
    else $error("read data shown outside an answer");

  unmapped_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    pslverr |-> prdata == '0)
    else $error("unmapped read returned data");

  preset_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
    (!preset_wr_w && !capture_w) |=> $stable(preset_q))
    else $error("preset changed without write or capture");
endmodule

// file: verilog/rtc_pkg.sv
// shared constants, field layout and encodings of the real-time clock counter
//
// Contract
// RULE1 - rate field 5:3 picks stop, 1 MHz..100 Hz, trigger one, or line frequency
// RULE2 - mode field 2:1 selects modes 0 to 3; counting follows rate and mode
// RULE3 - setting the run bit, bit 0, starts counter operation
// RULE4 - in modes 1, 2 and 3 run stays set until software clears it
// RULE5 - in mode 0 overflow clears the run bit
// RULE6 - while run is clear the counter is forced to zero and held
// RULE7 - clearing the overflow interrupt enable withdraws a pending overflow request
// RULE8 - software writes the two's complement interval to preset first, then control
// RULE9 - mode 1 run written high loads the counter from preset and counts
// RULE10 - mode 1 armed start waits for trigger two, then sets run and loads
// RULE11 - mode 1 overflow reloads from preset, sets overflow flag, requests interrupt
// RULE12 - overflow while overflow flag still set raises the overrun bit
// RULE13 - software reads control, clears overflow flag, may rearm the sequence
// RULE14 - mode 2 counts up from zero at the selected rate while run is set
// RULE15 - mode 2 trigger two captures the counter into preset and sets its flag
// RULE16 - mode 2 overflow sets the overflow flag and requests an enabled interrupt
// RULE17 - mode 2 keeps counting after captures and overflows until run written zero
// RULE18 - software should enable trigger two and overflow interrupts in mode 2
// RULE19 - trigger two sets its flag; run rise clears it unless armed start was set (code sets the flag only while running or armed)
// RULE20 - run rise clears the armed-start bit; when set, trigger two sets run
// RULE21 - overflow sets the overflow flag; run rise always clears it
// RULE22 - with armed start set, trigger two flag sets run and clears armed start
// RULE23 - trigger two while its flag is set also raises the overrun bit (code does so only while running or armed)
// RULE24 - simultaneous enabled requests give overflow priority over trigger two
// RULE25 - external inputs are synchronised and edge detected, one event per pulse
package rtc_pkg;
  // timebase: the 1 MHz rate is derived from the system clock, then decades
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_PERIOD_NS = 1000;
  localparam int BASE_DIV = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DECADE_STAGES = 4;
  localparam logic [3:0] DECADE_LAST = 4'h9;

  // register byte addresses
  localparam logic [7:0] ADDR_CSR = 8'h00;
  localparam logic [7:0] ADDR_PRESET = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;

  // control/status field positions
  localparam int CSR_RUN = 0;
  localparam int CSR_MODE_LO = 1;
  localparam int CSR_MODE_HI = 2;
  localparam int CSR_RATE_LO = 3;
  localparam int CSR_RATE_HI = 5;
  localparam int CSR_OVF_EN = 6;
  localparam int CSR_OVF_FLAG = 7;
  localparam int CSR_OVERRUN = 12;
  localparam int CSR_TSR = 13;
  localparam int CSR_T2_EN = 14;
  localparam int CSR_T2_FLAG = 15;

  // reset values
  localparam logic [15:0] PRESET_RST = 16'h0000;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_REPEAT, MODE_EVENT, MODE_SPARE} mode_t;
  typedef enum logic [2:0] {
    RATE_STOP, RATE_1MHZ, RATE_100KHZ, RATE_10KHZ, RATE_1KHZ, RATE_100HZ,
    RATE_TRIG1, RATE_LINE
  } rate_t;
endpackage

// file: verilog/timebase_if.sv
// link between the rate source and the counter core
`timescale 1ns/1ps
interface timebase_if;
  logic [2:0] rate;
  logic count_tick;
  logic trig_two_evt;
  modport src (input rate, output count_tick, output trig_two_evt);
  modport sink (output rate, input count_tick, input trig_two_evt);
endinterface

// file: verilog/rate_source.sv
// input synchronisers, decade timebase and count-rate selection
`timescale 1ns/1ps
module rate_source (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ext_trig_one,
  input wire logic ext_trig_two,
  input wire logic line_freq,
  timebase_if.src tb
);
  localparam int DECADE_STAGES = rtc_pkg::DECADE_STAGES;
  logic [2:0] raw_w;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic [2:0] edge_w;
  logic [7:0] pre_q;
  logic [DECADE_STAGES:0] tick_w;
  logic [2:0] idx_w;
  logic sel_tick_w;

  assign raw_w = {line_freq, ext_trig_two, ext_trig_one};

  // two-flop synchronisers, the edge detector only sees the second stage;
  // one process holds all three so that no vector has several writers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // rising edges only, one event per pulse
  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    assign edge_w[g] = sync_q[g] & ~prev_q[g]; // RULE25
  end

  // prescaler down to the 1 MHz base
  assign tick_w[0] = (pre_q == 8'(rtc_pkg::BASE_DIV - 1));
  always_ff @(posedge clk) begin
    if (!reset_n) pre_q <= 8'h00;
    else pre_q <= tick_w[0] ? 8'h00 : pre_q + 8'h01;
  end

  // decade chain: each stage ticks once per ten ticks of the one before
  for (g = 0; g < DECADE_STAGES; g++) begin : g_dec
    logic [3:0] dec_q;
    always_ff @(posedge clk) begin
      if (!reset_n) dec_q <= 4'h0;
      else if (tick_w[g]) dec_q <= (dec_q == rtc_pkg::DECADE_LAST) ? 4'h0 : dec_q + 4'h1;
    end
    assign tick_w[g+1] = tick_w[g] & (dec_q == rtc_pkg::DECADE_LAST);
  end

  // source selection; stop gives no ticks at all
  assign idx_w = tb.rate - 3'h1;
  assign sel_tick_w = (tb.rate == rtc_pkg::RATE_STOP) ? 1'b0 :
                      (tb.rate == rtc_pkg::RATE_TRIG1) ? edge_w[0] :
                      (tb.rate == rtc_pkg::RATE_LINE) ? edge_w[2] :
                      tick_w[idx_w]; // RULE1

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tb.count_tick <= 1'b0;
      tb.trig_two_evt <= 1'b0;
    end else begin
      tb.count_tick <= sel_tick_w;
      tb.trig_two_evt <= edge_w[1]; // RULE25
    end
  end
endmodule

// file: testbench/trig_source.sv
// model of the external trigger and line-frequency sources
`timescale 1ns/1ps
module trig_source (
  input wire logic clk,
  output logic ext_trig_one,
  output logic ext_trig_two,
  output logic line_freq
);
  initial begin
    ext_trig_one = 1'b0;
    ext_trig_two = 1'b0;
    line_freq = 1'b0;
  end

  // one pulse on each selected line; high and low three cycles each, above the two-cycle minimum
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    ext_trig_one <= m[0];
    ext_trig_two <= m[1];
    line_freq <= m[2];
    repeat (3) @(posedge clk);
    ext_trig_one <= 1'b0;
    ext_trig_two <= 1'b0;
    line_freq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking testbench of the real-time clock counter over apb
`timescale 1ns/1ps
module tb_top;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, p;
  logic t_one, t_two, line, ovf_irq, t2_irq, e;
  int errors, compares;
  localparam logic [31:0] OVF = 32'h00000080;
  localparam logic [31:0] OVR = 32'h00001000;
  localparam logic [31:0] T2F = 32'h00008000;
  localparam logic [7:0] CONTROL_STATUS = rtc_pkg::ADDR_CSR;
  localparam logic [7:0] PRE = rtc_pkg::ADDR_PRESET;
  localparam logic [7:0] CNT = rtc_pkg::ADDR_COUNT;

  programmable_realtime_clock_counter programmable_realtime_clock_counter_i (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_one(t_one), .ext_trig_two(t_two), .line_freq(line),
    .overflow_irq_req(ovf_irq), .trigger_two_irq_req(t2_irq));

  trig_source trig_source_i (.clk(clk), .ext_trig_one(t_one), .ext_trig_two(t_two),
    .line_freq(line));

  always #25 clk = ~clk;

  // control word from its fields
  function automatic logic [31:0] cw(int run, int md, int rt, int oe, int te, int ts);
    cw = 32'h00000000;
    cw[rtc_pkg::CSR_RUN] = run[0];
    cw[rtc_pkg::CSR_MODE_HI:rtc_pkg::CSR_MODE_LO] = md[1:0];
    cw[rtc_pkg::CSR_RATE_HI:rtc_pkg::CSR_RATE_LO] = rt[2:0];
    cw[rtc_pkg::CSR_OVF_EN] = oe[0];
    cw[rtc_pkg::CSR_T2_EN] = te[0];
    cw[rtc_pkg::CSR_TSR] = ts[0];
  endfunction

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_q, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t no pready", $time);
    end
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    apb(1'b0, a, 32'h00000000, v, e);
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog; the whole sequence needs well under two thousand cycles
  initial begin
    idle(6000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    errors = 0;
    compares = 0;
    idle(2);
    reset_n <= 1'b1;
    // reset values, unmapped address and read-only counter
    rd(CONTROL_STATUS, r);
    chk32(r, 32'h00000000, "csr reset");
    chk1(e, 1'b0, "mapped no error");
    rd(PRE, r);
    chk32(r, 32'h00000000, "preset reset");
    apb(1'b0, 8'h0C, 32'h00000000, r, e);
    chk1(e, 1'b1, "unmapped error");
    chk32(r, 32'h00000000, "unmapped reads zero");
    wr(CNT, 32'h00000005);
    rd(CNT, r);
    chk32(r, 32'h00000000, "stopped counter");
    // mode 0: overflow stops the run and zeroes the counter
    wr(PRE, 32'h0000FFFE);
    wr(CONTROL_STATUS, cw(1, 0, 1, 1, 0, 0));
    idle(100);
    rd(CONTROL_STATUS, r);
    chk32(r, cw(0, 0, 1, 1, 0, 0) | OVF, "mode 0 csr");
    rd(CNT, r);
    chk32(r, 32'h00000000, "mode 0 counter");
    chk1(ovf_irq, 1'b1, "ovf request");
    wr(CONTROL_STATUS, cw(0, 0, 1, 0, 0, 0) | OVF);
    idle(2);
    chk1(ovf_irq, 1'b0, "ovf request withdrawn");
    // mode 1: repeated reloads, overrun, and priority of the overflow request
    wr(CONTROL_STATUS, cw(1, 1, 1, 1, 1, 0) | OVF);
    rd(CONTROL_STATUS, r);
    chk32(r, cw(1, 1, 1, 1, 1, 0), "run rise clears flag");
    idle(150);
    trig_source_i.pulse(3'b010);
    idle(6);
    rd(CONTROL_STATUS, r);
    chk32(r, cw(1, 1, 1, 1, 1, 0) | OVF | OVR | T2F, "mode 1 csr");
    rd(CNT, r);
    chk32({r[31:1], 1'b0}, 32'h0000FFFE, "mode 1 reload");
    chk1(ovf_irq, 1'b1, "ovf request high");
    chk1(t2_irq, 1'b0, "t2 request masked");
    // mode 1 armed start by trigger two
    wr(CONTROL_STATUS, cw(0, 1, 2, 0, 1, 1));
    rd(CNT, r);
    chk32(r, 32'h00000000, "cleared run zeroes");
    trig_source_i.pulse(3'b010);
    idle(2);
    rd(CONTROL_STATUS, r);
    chk32(r, cw(1, 1, 2, 0, 1, 0) | T2F, "armed start csr");
    rd(CNT, r);
    chk32({r[31:1], 1'b0}, 32'h0000FFFE, "armed start load");
    chk1(t2_irq, 1'b1, "t2 request");
    wr(CONTROL_STATUS, 32'h00000000);
    // mode 2: capture while counting, second capture overruns
    wr(CONTROL_STATUS, cw(1, 2, 1, 0, 1, 0));
    idle(100);
    trig_source_i.pulse(3'b010);
    rd(PRE, p);
    idle(25);
    rd(CNT, r);
    chk1(p[15:0] != 16'h0000, 1'b1, "capture nonzero");
    chk1(r[15:0] > p[15:0], 1'b1, "keeps counting");
    trig_source_i.pulse(3'b010);
    rd(CONTROL_STATUS, r);
    chk32(r, cw(1, 2, 1, 0, 1, 0) | T2F | OVR, "capture overrun");
    wr(CONTROL_STATUS, 32'h00000000);
    // external rates count one per pulse; stop rate counts nothing
    for (int i = 0; i < 3; i++) begin
      wr(CONTROL_STATUS, cw(1, 2 + (i == 2 ? 1 : 0), (i == 0) ? 0 : 5 + i, 0, 0, 0));
      repeat (3) trig_source_i.pulse(3'b101);
      idle(6);
      rd(CNT, r);
      chk32(r, (i == 0) ? 32'h00000000 : 32'h00000003, "external rate count");
      wr(CONTROL_STATUS, 32'h00000000);
    end
    end_sim();
  end
endmodule
